// *** hdl/cke_pkg.sv ***
// constants and types shared by the power-state sequencer
package cke_pkg;

    // command encodings on {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_NOP      = 4'h7;
    localparam logic [3:0] CMD_DESELECT = 4'hF;
    localparam logic [3:0] CMD_REFRESH  = 4'h1;
    localparam logic [3:0] CMD_MRS      = 4'h0;
    localparam logic [3:0] CMD_READ     = 4'h5;
    localparam logic [3:0] CMD_WRITE    = 4'h4;

    // timing figures in clock cycles (nCK)
    localparam int TCKE_NCK   = 3;
    localparam int TMOD_NCK   = 12;
    localparam int TXS_NCK    = 112;
    localparam int TXSDLL_NCK = 512;
    localparam int TWR_SRX_NCK = 512;
    localparam int TXP_NCK    = 3;
    localparam int CNT_W      = 10;

    typedef enum logic [5:0] {
        ST_IDLE     = 6'h01,
        ST_ACTIVE   = 6'h02,
        ST_PPD      = 6'h04,
        ST_APD      = 6'h08,
        ST_SREF     = 6'h10,
        ST_EXIT     = 6'h20
    } pstate_t;

endpackage : cke_pkg

// *** hdl/cke_timer_if.sv ***
// interface between the sequencer and its wait timer
interface cke_timer_if;
    logic                    load;
    logic [cke_pkg::CNT_W-1:0] value;
    logic                    done;
    modport ctrl (output load, output value, input done);
    modport tmr  (input load, input value, output done);
endinterface : cke_timer_if

// *** hdl/cke_timer.sv ***
// down counter that times waits after each cke edge except the first rise after reset
module cke_timer (
    input  wire logic core_clk,
    input  wire logic resetn,
    cke_timer_if.tmr  t
);
    logic [cke_pkg::CNT_W-1:0] cnt_reg;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= '0;
        end else if (t.load) begin
            cnt_reg <= t.value;
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    // done looks only at the count: folding load in would loop back through the
    // sequencer's decision logic within the same cycle
    assign t.done = (cnt_reg == '0);
endmodule : cke_timer

// *** hdl/cke_power_ctrl.sv ***
// host-side sequencer that drives cke and commands for power-down and self refresh
// Function
// - drop cke only after mode delays
// - nop or deselect on power-down cke edges
// - nop or deselect on self refresh exit
// - self refresh only from idle with refresh
// - no self refresh during read or write
// - hold cke for minimum pulse time, except the first high pulse after reset
// - only nop or deselect during exit time
// - no read or odt before dll exit
// - no write before 512 cycles after exit
// - avoid all unlisted sequences
// - only legal commands in other states
module cke_power_ctrl #(
    parameter int TXSDLL = cke_pkg::TXSDLL_NCK
) (
    input  wire logic       core_clk,
    input  wire logic       resetn,
    // user requests, levels held until taken; pd_req, sr_req and wake_req are not latched
    input  wire logic       pd_req,
    input  wire logic       sr_req,
    input  wire logic       wake_req,
    input  wire logic       banks_open,
    input  wire logic       burst_busy,
    input  wire logic       mrs_issued,
    input  wire logic       user_cmd_valid,
    input  wire logic [3:0] user_cmd,
    input  wire logic       user_odt,
    output logic            user_cmd_ready,
    output logic            read_allowed,
    output logic            write_allowed,
    output logic            in_low_power,
    output logic [5:0]      state_out,
    // device pins
    output logic            ddr_cke,
    output logic            ddr_cs_n,
    output logic            ddr_ras_n,
    output logic            ddr_cas_n,
    output logic            ddr_we_n,
    output logic            ddr_odt
);
    // ==========================================================
    // state
    // ==========================================================
    cke_pkg::pstate_t state_reg;
    cke_pkg::pstate_t state_next;
    logic [3:0]       cmd_next;
    logic             cke_next;
    logic             odt_next;
    logic             load;
    logic [cke_pkg::CNT_W-1:0] value;
    logic [cke_pkg::CNT_W-1:0] mod_cnt_reg;
    logic [cke_pkg::CNT_W-1:0] dll_cnt_reg;
    logic [cke_pkg::CNT_W-1:0] wr_cnt_reg;
    logic             hold_done;
    logic             dll_done;
    logic             wr_done;

    cke_timer_if tif ();
    assign tif.load  = load;
    assign tif.value = value;
    assign hold_done = tif.done;

    cke_timer u_timer (
        .core_clk (core_clk),
        .resetn   (resetn),
        .t        (tif)
    );

    function automatic logic is_quiet(input logic [3:0] c);
        is_quiet = (c == cke_pkg::CMD_NOP) || c[3];
    endfunction : is_quiet

    // reads wait for the dll to relock, writes for the long self refresh exit count
    function automatic logic cmd_allowed(input logic [3:0] c,
                                         input logic       rd_ok,
                                         input logic       wr_ok);
        if (is_quiet(c)) begin
            cmd_allowed = 1'b1;
        end else if (c == cke_pkg::CMD_READ) begin
            cmd_allowed = rd_ok;
        end else if (c == cke_pkg::CMD_WRITE) begin
            cmd_allowed = wr_ok;
        end else begin
            cmd_allowed = 1'b1;
        end
    endfunction : cmd_allowed

    // ==========================================================
    // mode register delay tracking
    // ==========================================================
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mod_cnt_reg <= '0;
        end else if (mrs_issued) begin
            mod_cnt_reg <= cke_pkg::CNT_W'(cke_pkg::TMOD_NCK);
        end else if (mod_cnt_reg != '0) begin
            mod_cnt_reg <= mod_cnt_reg - 1'b1;
        end
    end

    // ==========================================================
    // self refresh exit counters
    // ==========================================================
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            dll_cnt_reg <= '0;
            wr_cnt_reg  <= '0;
        end else if (state_reg == cke_pkg::ST_SREF && state_next == cke_pkg::ST_EXIT) begin
            dll_cnt_reg <= cke_pkg::CNT_W'(TXSDLL);
            wr_cnt_reg  <= cke_pkg::CNT_W'(cke_pkg::TWR_SRX_NCK);
        end else begin
            if (dll_cnt_reg != '0) dll_cnt_reg <= dll_cnt_reg - 1'b1;
            if (wr_cnt_reg != '0) wr_cnt_reg <= wr_cnt_reg - 1'b1;
        end
    end

    // ==========================================================
    // next state
    // ==========================================================
    always_comb begin
        state_next = state_reg;
        cmd_next   = cke_pkg::CMD_DESELECT;
        cke_next   = ddr_cke;
        load       = 1'b0;
        value      = '0;
        user_cmd_ready = 1'b0;
        case (state_reg)
            cke_pkg::ST_IDLE, cke_pkg::ST_ACTIVE: begin
                state_next = banks_open ? cke_pkg::ST_ACTIVE : cke_pkg::ST_IDLE;
                // nothing reaches the pins until cke is up after reset
                user_cmd_ready = ddr_cke;
                if (ddr_cke && hold_done && mod_cnt_reg == '0 && !mrs_issued) begin
                    // entry only from the registered idle state, so a bank that the user
                    // has just closed gets one cycle to show up in the state first
                    if (sr_req && state_reg == cke_pkg::ST_IDLE && !banks_open
                        && !burst_busy) begin
                        user_cmd_ready = 1'b0;
                        cmd_next       = cke_pkg::CMD_REFRESH;
                        cke_next       = 1'b0;
                        state_next     = cke_pkg::ST_SREF;
                        load           = 1'b1;
                        value          = cke_pkg::CNT_W'(cke_pkg::TCKE_NCK - 1);
                    end else if (pd_req && !burst_busy) begin
                        user_cmd_ready = 1'b0;
                        cke_next       = 1'b0;
                        state_next     = banks_open ? cke_pkg::ST_APD : cke_pkg::ST_PPD;
                        load           = 1'b1;
                        value          = cke_pkg::CNT_W'(cke_pkg::TCKE_NCK - 1);
                    end
                end
                if (user_cmd_ready && user_cmd_valid
                    && cmd_allowed(user_cmd, dll_done, wr_done)) begin
                    cmd_next = user_cmd;
                end
            end
            cke_pkg::ST_PPD, cke_pkg::ST_APD, cke_pkg::ST_SREF: begin
                if (wake_req && hold_done) begin
                    cke_next   = 1'b1;
                    state_next = cke_pkg::ST_EXIT;
                    load       = 1'b1;
                    value      = (state_reg == cke_pkg::ST_SREF) ?
                                 cke_pkg::CNT_W'(cke_pkg::TXS_NCK) :
                                 cke_pkg::CNT_W'(cke_pkg::TXP_NCK);
                end
            end
            cke_pkg::ST_EXIT: begin
                if (hold_done) state_next = banks_open ? cke_pkg::ST_ACTIVE : cke_pkg::ST_IDLE;
            end
            default: state_next = cke_pkg::ST_IDLE;
        endcase
    end

    // ==========================================================
    // registers and pins
    // ==========================================================
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= cke_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // cke comes up on the first edge after reset, with a deselect on the pins
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ddr_cke <= 1'b0;
        end else if (state_reg == cke_pkg::ST_IDLE && !ddr_cke) begin
            ddr_cke <= 1'b1;
        end else begin
            ddr_cke <= cke_next;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= cke_pkg::CMD_DESELECT;
        end else begin
            {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= cmd_next;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ddr_odt <= 1'b0;
        end else begin
            ddr_odt <= odt_next;
        end
    end

    // termination off in low power and before the dll has relocked
    assign dll_done = (dll_cnt_reg == '0);
    assign wr_done  = (wr_cnt_reg == '0);
    assign odt_next = user_odt && dll_done && user_cmd_ready;

    assign read_allowed  = user_cmd_ready && dll_done;
    assign write_allowed = user_cmd_ready && wr_done;
    assign in_low_power  = (state_reg == cke_pkg::ST_PPD) || (state_reg == cke_pkg::ST_APD)
                        || (state_reg == cke_pkg::ST_SREF);
    assign state_out     = state_reg;
endmodule : cke_power_ctrl

// *** bench/cke_power_ctrl_chk.sv ***
// pin-level assertions for the power-state sequencer
module cke_power_ctrl_chk (
    input wire logic       core_clk,
    input wire logic       resetn,
    input wire logic       banks_open,
    input wire logic       burst_busy,
    input wire logic [5:0] state_out,
    input wire logic       ddr_cke,
    input wire logic       ddr_cs_n,
    input wire logic       ddr_ras_n,
    input wire logic       ddr_cas_n,
    input wire logic       ddr_we_n,
    input wire logic       ddr_odt
);
    // ====================================================
    // properties
    wire [3:0] cmd = {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n};
    wire       idle_cmd = cmd[3] || cmd == 4'h7;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    a_fall_quiet: assert property ($fell(ddr_cke) |-> idle_cmd || cmd == 4'h1)
        else $error("busy command at cke fall");
    a_rise_quiet: assert property ($rose(ddr_cke) |-> idle_cmd)
        else $error("busy command at cke rise");
    a_hold_high: assert property ($rose(ddr_cke) |=> ddr_cke [*2])
        else $error("cke high pulse too short");
    a_hold_low: assert property ($fell(ddr_cke) |=> !ddr_cke [*2])
        else $error("cke low pulse too short");
    a_sref_entry: assert property ($fell(ddr_cke) && cmd == 4'h1 |->
        $past(state_out) == 6'h01 && !$past(banks_open) && !$past(burst_busy))
        else $error("self refresh entered from a busy state");
    a_pd_mode: assert property ($fell(ddr_cke) && cmd != 4'h1 |->
        state_out == ($past(banks_open) ? 6'h08 : 6'h04))
        else $error("wrong power-down mode");
    a_exit_quiet: assert property (state_out == 6'h20 |-> idle_cmd)
        else $error("command during exit wait");
    a_odt_off: assert property (state_out inside {6'h10, 6'h20} |-> !ddr_odt)
        else $error("termination on in self refresh or exit");
endmodule : cke_power_ctrl_chk
bind cke_power_ctrl cke_power_ctrl_chk chk_i (.core_clk, .resetn, .banks_open, .burst_busy,
    .state_out, .ddr_cke, .ddr_cs_n, .ddr_ras_n, .ddr_cas_n, .ddr_we_n, .ddr_odt);

// *** bench/ddr_dev_model.sv ***
// behavioural memory that follows its power state from the pins
module ddr_dev_model (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       cke,
    input  wire logic [3:0] cmd,
    input  wire logic       odt,
    output logic [5:0]      dev_st,
    output logic            bad
);
    // ====================================================
    // state tracking
    logic cke_d;
    logic open_q;
    wire  quiet = cmd[3] || cmd == 4'h7;
    wire  sre   = cmd == 4'h1 && !open_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {cke_d, open_q, bad} <= 3'h0;
            dev_st <= 6'h01;
        end else begin
            cke_d <= cke;
            if (cke_d && cke && !cmd[3] && cmd[2:1] == 2'h1)
                open_q <= cmd[0];
            // low on both edges: pins ignored, no self-refresh in power-down
            if (cke_d && !cke)
                dev_st <= sre ? 6'h10 : (open_q ? 6'h08 : 6'h04);
            else if (cke)
                dev_st <= open_q ? 6'h02 : 6'h01;
            if (cke_d != cke && !quiet && !(cke_d && sre))
                bad <= 1'b1;
            if (dev_st == 6'h10 && odt)
                bad <= 1'b1;
        end
    end
endmodule : ddr_dev_model

// *** bench/test_sdram_cke_power_state_control.sv ***
// bench for the power-state sequencer against the memory model
module test_sdram_cke_power_state_control;
    timeunit 1ns;
    timeprecision 1ps;
    // ====================================================
    // signals and instances
    logic       core_clk, resetn, pd_req, sr_req, wake_req, banks_open, burst_busy;
    logic       mrs_issued, user_cmd_valid, user_odt, rdy, rd_ok, wr_ok;
    logic       cke, cs_n, ras_n, cas_n, we_n, odt, bad, lp;
    logic [3:0] user_cmd;
    logic [5:0] st, dev_st;
    int         fail_count = 0, n_checks = 0, cyc = 0, n, r;
    // dll wait longer than the exit wait, so the read gate is seen closed after exit
    cke_power_ctrl #(.TXSDLL(200)) dut (.core_clk, .resetn, .pd_req, .sr_req, .wake_req,
        .banks_open, .burst_busy, .mrs_issued, .user_cmd_valid, .user_cmd, .user_odt,
        .user_cmd_ready(rdy), .read_allowed(rd_ok), .write_allowed(wr_ok), .in_low_power(lp),
        .state_out(st), .ddr_cke(cke), .ddr_cs_n(cs_n), .ddr_ras_n(ras_n),
        .ddr_cas_n(cas_n), .ddr_we_n(we_n), .ddr_odt(odt));
    ddr_dev_model mem (.clk(core_clk), .rstn(resetn), .cke, .cmd({cs_n, ras_n, cas_n, we_n}),
        .odt, .dev_st, .bad);
    initial begin
        core_clk = 0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            stop_test();
        end
    end
    // ====================================================
    // tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic req(ref logic rq, input logic [5:0] exp);
        rq = 1;
        for (n = 0; n < 300 && st !== exp; n++) @(negedge core_clk);
        rq = 0;
    endtask : req
    task automatic wake();
        req(wake_req, 6'h20);
        for (n = 0; n < 300 && st === 6'h20; n++) @(negedge core_clk);
    endtask : wake
    task automatic send(input logic [3:0] c);
        user_cmd = c;
        user_cmd_valid = 1;
        for (int i = 0; i < 50 && rdy !== 1'b1; i++) @(negedge core_clk);
        @(negedge core_clk);
        user_cmd_valid = 0;
        user_cmd = 4'hF;
    endtask : send
    task automatic t_pd(input logic open);
        banks_open = open;
        if (open) send(4'h3);
        req(pd_req, open ? 6'h08 : 6'h04);
        chk(st, open ? 6'h08 : 6'h04);
        chk(lp, 1);
        // the memory registers the low cke one edge after the pins change
        @(negedge core_clk);
        chk(dev_st, open ? 6'h08 : 6'h04);
        wake();
        chk(dev_st, open ? 6'h02 : 6'h01);
        chk(lp, 0);
        if (open) send(4'h2);
        banks_open = 0;
    endtask : t_pd
    task automatic t_sr();
        user_odt = 1;
        req(sr_req, 6'h10);
        repeat (4) @(negedge core_clk);
        chk(dev_st, 6'h10);
        chk(odt, 0);
        chk(lp, 1);
        wake();
        chk(n >= cke_pkg::TXS_NCK, 1);
        chk(rd_ok, 0);
        chk(odt, 0);
        for (r = 0; r < 600 && wr_ok !== 1'b1; r++) @(negedge core_clk);
        chk(r + n >= 512, 1);
        chk(rd_ok, 1);
        chk(odt, 1);
        user_odt = 0;
    endtask : t_sr
    task automatic t_refuse();
        banks_open = 1;
        sr_req = 1;
        repeat (30) @(negedge core_clk);
        chk(cke, 1);
        {banks_open, burst_busy, pd_req} = 3'h3;
        repeat (30) @(negedge core_clk);
        chk(cke, 1);
        {sr_req, pd_req, burst_busy} = 3'h0;
    endtask : t_refuse
    task automatic t_mrs();
        mrs_issued = 1;
        @(negedge core_clk);
        mrs_issued = 0;
        req(pd_req, 6'h04);
        chk(n >= cke_pkg::TMOD_NCK, 1);
        wake();
    endtask : t_mrs
    task automatic stop_test();
        if (fail_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test
    // ====================================================
    // main sequence
    initial begin
        {pd_req, sr_req, wake_req, banks_open, burst_busy, mrs_issued} = 6'h00;
        {user_cmd_valid, user_odt, resetn} = 3'h0;
        user_cmd = 4'hF;
        repeat (20) @(negedge core_clk);
        resetn = 1;
        repeat (3) @(negedge core_clk);
        chk(st, 6'h01);
        t_pd(0);
        t_pd(1);
        t_sr();
        t_refuse();
        t_mrs();
        chk(bad, 0);
        stop_test();
    end
endmodule : test_sdram_cke_power_state_control
